// [rtl/hvir_pkg.sv]
// constants, types and carriers shared by the version and id rom access block
// assumes a 32-bit apb register bus and a byte-wide eeprom fetch port outside

package hvir_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int APB_AW = 8;
	localparam logic [7:0] OFS_VERSION = 8'h00;
	localparam logic [7:0] OFS_ROM_ACCESS = 8'h04;

	// ****************************************************************
	// version register fields
	// ****************************************************************
	localparam int VER_PRESENT_BIT = 24;
	localparam int VER_MAJOR_LSB = 16;
	localparam int VER_MINOR_LSB = 0;
	localparam logic [7:0] VER_MAJOR = 8'h01;
	localparam logic [7:0] VER_MINOR = 8'h10;
	localparam logic PRESENT_RESET = 1'b0;

	// ****************************************************************
	// rom access register fields
	// ****************************************************************
	localparam int ROM_CLR_BIT = 31;
	localparam int ROM_RD_BIT = 25;
	localparam int ROM_DATA_LSB = 16;
	localparam int ROM_MINI_LSB = 0;
	localparam logic [7:0] READ_VALUE_RESET = 8'h00;
	localparam logic [7:0] MINI_RESET = 8'h00;
	localparam logic [7:0] MINI_SRC_ADDR = 8'h28;
	localparam logic [7:0] MINI_VALID_MIN = 8'h3a;

	// ****************************************************************
	// automatic load of the bus information record
	// ****************************************************************
	localparam logic [7:0] BIB_BASE = 8'h00;
	localparam int BIB_BYTES = 20;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		HVIR_ST_DETECT,
		HVIR_ST_BIB,
		HVIR_ST_MINI,
		HVIR_ST_READY,
		HVIR_ST_CLEAR,
		HVIR_ST_SW_READ
	} hvir_state_e;

	typedef enum logic {
		HVIR_FT_IDLE,
		HVIR_FT_WAIT
	} hvir_fetch_e;

	// byte request toward the eeprom
	typedef struct packed {
		logic req;
		logic [7:0] addr;
	} hvir_rom_cmd_s;

	// byte answer from the eeprom
	typedef struct packed {
		logic ack;
		logic [7:0] data;
	} hvir_rom_rsp_s;

endpackage

// [rtl/hvir_byte_fetch.sv]
// single byte fetch sequencer toward the serial eeprom controller
// assumes the far side holds ack high for one cycle with valid data

`timescale 1ns/10ps

module hvir_byte_fetch #(
	parameter int AW = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request from the access logic
	input wire logic start,
	input wire logic [AW-1:0] addr,
	output logic done,
	output logic [7:0] data,
	// eeprom byte port
	output hvir_pkg::hvir_rom_cmd_s rom_cmd,
	input wire hvir_pkg::hvir_rom_rsp_s rom_rsp
);

	// ****************************************************************
	// checks
	// ****************************************************************
	if (AW != 8) begin : g_bad_aw
		$error("hvir_byte_fetch: byte address must be 8 bits");
	end

	hvir_pkg::hvir_fetch_e state;
	logic [AW-1:0] held_addr;
	logic got;

	// answer accepted only while waiting
	assign got = (state == hvir_pkg::HVIR_FT_WAIT) && rom_rsp.ack;
	assign rom_cmd.req = (state == hvir_pkg::HVIR_FT_WAIT);
	assign rom_cmd.addr = held_addr;

	// one fetch at a time, address held until the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= hvir_pkg::HVIR_FT_IDLE;
			held_addr <= '0;
			done <= 1'b0;
			data <= 8'h00;
		end else begin
			done <= got;
			unique case (state)
				hvir_pkg::HVIR_FT_IDLE: begin
					if (start && !done) begin
						held_addr <= addr;
						state <= hvir_pkg::HVIR_FT_WAIT;
					end
				end
				hvir_pkg::HVIR_FT_WAIT: begin
					if (got) begin
						data <= rom_rsp.data;
						state <= hvir_pkg::HVIR_FT_IDLE;
					end
				end
			endcase
		end
	end

endmodule

// [rtl/hvir_top.sv]
// version register and id rom byte access port behind an apb slave
// assumes presetn is the global reset and sys_hw_reset a synchronous pulse
// assumes an eeprom controller that serves the byte fetch port

`timescale 1ns/10ps

// Function
// - version register bits 31 to 25 always read zero
// - present flag at bit 24 set when an eeprom is detected, else zero
// - present flag cleared only by global reset, kept through others
// - with eeprom present, load bus information record after hardware reset
// - version bits 23 to 16 read constant 01h
// - version bits 7 to 0 read 10h, bits 15 to 8 read zero
// - rom access bits 30 to 26, 24 and 15 to 8 read zero
// - writing bit 31 clears the rom byte address; bit clears when done
// - address clear leaves the read data field unchanged
// - writing bit 25 starts a read of the byte at the current address
// - read start bit clears itself when the byte read has finished
// - fetched byte lands in rom access bits 23 to 16
// - mini rom offset defaults to 00h and is read only
// - with eeprom fitted, mini rom offset loads from eeprom offset 28h
module hvir_top #(
	parameter int AW = 8,
	parameter logic [7:0] BIB_BASE = hvir_pkg::BIB_BASE,
	parameter int BIB_BYTES = hvir_pkg::BIB_BYTES
) (
	// clock and global reset
	input wire logic pclk,
	input wire logic presetn,
	// system hardware reset, keeps the present flag
	input wire logic sys_hw_reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hvir_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// eeprom detection and byte port
	input wire logic eeprom_detect,
	output hvir_pkg::hvir_rom_cmd_s rom_cmd,
	input wire hvir_pkg::hvir_rom_rsp_s rom_rsp,
	// bus information record stream to the link
	output logic bib_valid,
	output logic [7:0] bib_index,
	output logic [7:0] bib_byte,
	output logic bib_loaded,
	// mini rom offset to the rest of the device
	output logic [7:0] mini_rom_offset,
	output logic mini_rom_valid
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (AW != 8) begin : g_bad_aw
		$error("hvir_top: rom byte address must be 8 bits");
	end
	if (BIB_BYTES < 1 || BIB_BYTES > 256 - int'(BIB_BASE)) begin : g_bad_bib
		$error("hvir_top: bus information record must fit the eeprom");
	end

	// ****************************************************************
	// declarations
	// ****************************************************************
	hvir_pkg::hvir_state_e state;
	hvir_pkg::hvir_state_e next_state;
	logic eeprom_present_flag;
	logic rom_address_clear_request;
	logic rom_byte_read_request;
	logic [7:0] rom_byte_read_value;
	logic [AW-1:0] rom_addr;
	logic [7:0] bib_count;
	logic [7:0] bib_last;
	logic fetch_start;
	logic fetch_done;
	logic [7:0] fetch_data;
	logic [AW-1:0] fetch_addr;
	logic setup;
	logic access;
	logic hit_version;
	logic hit_rom;
	logic hit_any;
	logic wr_rom;
	logic idle;
	logic want_clear;
	logic want_read;
	logic [31:0] version_word;
	logic [31:0] rom_word;
	logic [31:0] read_mux;
	logic load_ok;

	// ****************************************************************
	// apb decode
	// ****************************************************************
	// no wait state: data registered in setup, answer in the first access cycle
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = access;
	assign hit_version = (paddr == hvir_pkg::OFS_VERSION);
	assign hit_rom = (paddr == hvir_pkg::OFS_ROM_ACCESS);
	assign hit_any = hit_version || hit_rom;
	assign wr_rom = access && pwrite && hit_rom;

	// ****************************************************************
	// register words
	// ****************************************************************
	// upper bits zero
	assign version_word = (32'(eeprom_present_flag) << hvir_pkg::VER_PRESENT_BIT)
		| (32'(hvir_pkg::VER_MAJOR) << hvir_pkg::VER_MAJOR_LSB)
		| (32'(hvir_pkg::VER_MINOR) << hvir_pkg::VER_MINOR_LSB);

	assign rom_word = (32'(rom_address_clear_request) << hvir_pkg::ROM_CLR_BIT)
		| (32'(rom_byte_read_request) << hvir_pkg::ROM_RD_BIT)
		| (32'(rom_byte_read_value) << hvir_pkg::ROM_DATA_LSB)
		| (32'(mini_rom_offset) << hvir_pkg::ROM_MINI_LSB);

	assign read_mux = hit_version ? version_word : (hit_rom ? rom_word : 32'h00000000);

	// read data and error captured at the setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h00000000 : read_mux;
			pslverr <= !hit_any;
		end
	end

	// ****************************************************************
	// presence detection
	// ****************************************************************
	// sticky presence flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eeprom_present_flag <= hvir_pkg::PRESENT_RESET;
		end else if (eeprom_detect) begin
			eeprom_present_flag <= 1'b1;
		end
	end

	// ****************************************************************
	// software request decode
	// ****************************************************************
	// writes ignored while busy
	assign idle = (state == hvir_pkg::HVIR_ST_READY)
		&& !rom_address_clear_request && !rom_byte_read_request;
	assign want_clear = wr_rom && idle && pwdata[hvir_pkg::ROM_CLR_BIT];
	assign want_read = wr_rom && idle && pwdata[hvir_pkg::ROM_RD_BIT];

	// ****************************************************************
	// sequencing
	// ****************************************************************
	assign bib_last = 8'(BIB_BYTES - 1);
	assign load_ok = eeprom_present_flag || eeprom_detect;

	// next state of the access sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			hvir_pkg::HVIR_ST_DETECT: begin
				next_state = load_ok ? hvir_pkg::HVIR_ST_BIB : hvir_pkg::HVIR_ST_READY;
			end
			hvir_pkg::HVIR_ST_BIB: begin
				if (fetch_done && bib_count == bib_last) begin
					next_state = hvir_pkg::HVIR_ST_MINI;
				end
			end
			hvir_pkg::HVIR_ST_MINI: begin
				if (fetch_done) begin
					next_state = hvir_pkg::HVIR_ST_READY;
				end
			end
			hvir_pkg::HVIR_ST_READY: begin
				if (rom_address_clear_request) begin
					next_state = hvir_pkg::HVIR_ST_CLEAR;
				end else if (rom_byte_read_request) begin
					next_state = eeprom_present_flag ? hvir_pkg::HVIR_ST_SW_READ : hvir_pkg::HVIR_ST_READY;
				end
			end
			hvir_pkg::HVIR_ST_CLEAR: begin
				next_state = hvir_pkg::HVIR_ST_READY;
			end
			hvir_pkg::HVIR_ST_SW_READ: begin
				if (fetch_done) begin
					next_state = hvir_pkg::HVIR_ST_READY;
				end
			end
			default: begin
				next_state = hvir_pkg::HVIR_ST_READY;
			end
		endcase
	end

	// fetch runs in every loading or reading state
	assign fetch_start = (state == hvir_pkg::HVIR_ST_BIB)
		|| (state == hvir_pkg::HVIR_ST_MINI)
		|| (state == hvir_pkg::HVIR_ST_SW_READ);

	assign fetch_addr = (state == hvir_pkg::HVIR_ST_BIB) ? AW'(BIB_BASE + bib_count)
		: ((state == hvir_pkg::HVIR_ST_MINI) ? hvir_pkg::MINI_SRC_ADDR : rom_addr);

	// state register, a hardware reset restarts the load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= hvir_pkg::HVIR_ST_DETECT;
		end else if (sys_hw_reset) begin
			state <= hvir_pkg::HVIR_ST_DETECT;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// software requests and rom address
	// ****************************************************************
	// request bits, set by software, cleared by the sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_address_clear_request <= 1'b0;
			rom_byte_read_request <= 1'b0;
		end else if (sys_hw_reset) begin
			rom_address_clear_request <= 1'b0;
			rom_byte_read_request <= 1'b0;
		end else begin
			if (want_clear) begin
				rom_address_clear_request <= 1'b1;
			end else if (state == hvir_pkg::HVIR_ST_CLEAR) begin
				rom_address_clear_request <= 1'b0;
			end
			if (want_read) begin
				rom_byte_read_request <= 1'b1;
			end else if (state == hvir_pkg::HVIR_ST_SW_READ && fetch_done) begin
				rom_byte_read_request <= 1'b0;
			end else if (state == hvir_pkg::HVIR_ST_READY && !rom_address_clear_request
				&& !eeprom_present_flag) begin
				// no eeprom: nothing to fetch, request retires at once
				rom_byte_read_request <= 1'b0;
			end
		end
	end

	// rom byte address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_addr <= '0;
		end else if (sys_hw_reset || state == hvir_pkg::HVIR_ST_CLEAR) begin
			rom_addr <= '0;
		end else if (state == hvir_pkg::HVIR_ST_SW_READ && fetch_done) begin
			rom_addr <= rom_addr + AW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rom_byte_read_value <= hvir_pkg::READ_VALUE_RESET;
		end else if (state == hvir_pkg::HVIR_ST_SW_READ && fetch_done) begin
			rom_byte_read_value <= fetch_data;
		end
	end

	// ****************************************************************
	// automatic load
	// ****************************************************************
	// bus information record stream
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bib_count <= 8'h00;
			bib_valid <= 1'b0;
			bib_index <= 8'h00;
			bib_byte <= 8'h00;
			bib_loaded <= 1'b0;
		end else if (sys_hw_reset) begin
			bib_count <= 8'h00;
			bib_valid <= 1'b0;
			bib_loaded <= 1'b0;
		end else begin
			bib_valid <= 1'b0;
			if (state == hvir_pkg::HVIR_ST_BIB && fetch_done) begin
				bib_valid <= 1'b1;
				bib_index <= bib_count;
				bib_byte <= fetch_data;
				bib_count <= bib_count + 8'h01;
				bib_loaded <= (bib_count == bib_last);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mini_rom_offset <= hvir_pkg::MINI_RESET;
		end else if (sys_hw_reset) begin
			mini_rom_offset <= hvir_pkg::MINI_RESET;
		end else if (state == hvir_pkg::HVIR_ST_MINI && fetch_done) begin
			mini_rom_offset <= fetch_data;
		end
	end

	assign mini_rom_valid = (mini_rom_offset > hvir_pkg::MINI_VALID_MIN);

	// ****************************************************************
	// eeprom byte fetch
	// ****************************************************************
	hvir_byte_fetch #(
		.AW(AW)
	) u_fetch (
		.pclk(pclk),
		.presetn(presetn),
		.start(fetch_start),
		.addr(fetch_addr),
		.done(fetch_done),
		.data(fetch_data),
		.rom_cmd(rom_cmd),
		.rom_rsp(rom_rsp)
	);

endmodule

// [test/hvir_eeprom_model.sv]
// eeprom byte port model answering after a chosen delay
// assumes the block holds req and addr until it sees ack
`timescale 1ns/10ps
module hvir_eeprom_model #(
	parameter logic [7:0] MINI_VAL = 8'h40
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// answer delay in cycles
	input wire logic [3:0] dly,
	// byte port
	input wire hvir_pkg::hvir_rom_cmd_s rom_cmd,
	output hvir_pkg::hvir_rom_rsp_s rom_rsp
);
	logic [3:0] wait_cnt;
	wire logic [7:0] content = (rom_cmd.addr == 8'h28) ? MINI_VAL : rom_cmd.addr ^ 8'ha5;
	wire logic hit = rom_cmd.req && !rom_rsp.ack && wait_cnt >= dly;
	// one ack per request; data line toggles outside the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt <= 4'h0;
			rom_rsp <= '0;
		end else begin
			rom_rsp.ack <= hit;
			rom_rsp.data <= hit ? content : ~rom_rsp.data;
			wait_cnt <= (rom_cmd.req && !hit) ? wait_cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// [test/hvir_top_chk.sv]
// checker for the version and id rom access block
// assumes binding to hvir_top, sees its ports only
`timescale 1ns/10ps
module hvir_top_chk #(
	parameter logic [7:0] BIB_BASE = 8'h00
) (
	// clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sys_hw_reset,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hvir_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] prdata,
	// eeprom and device side
	input wire logic eeprom_detect,
	input wire hvir_pkg::hvir_rom_cmd_s rom_cmd,
	input wire hvir_pkg::hvir_rom_rsp_s rom_rsp,
	input wire logic bib_valid,
	input wire logic [7:0] bib_index,
	input wire logic [7:0] bib_byte,
	input wire logic [7:0] mini_rom_offset,
	input wire logic mini_rom_valid
);
	logic seen_det;
	logic [7:0] last_addr;
	logic [7:0] last_data;
	// setup cycles of register reads
	wire logic rd_ver = psel && !penable && !pwrite && paddr == hvir_pkg::OFS_VERSION;
	wire logic rd_rom = psel && !penable && !pwrite && paddr == hvir_pkg::OFS_ROM_ACCESS;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// sticky detect and last eeprom answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_det <= 1'b0;
			last_addr <= 8'h00;
			last_data <= 8'h00;
		end else begin
			seen_det <= seen_det | eeprom_detect;
			if (rom_rsp.ack) begin
				last_addr <= rom_cmd.addr;
				last_data <= rom_rsp.data;
			end
		end
	end
	a_version_upper: assert property (rd_ver |=> prdata[31:25] == 7'h00 && prdata[23:16] == 8'h01)
		else $error("version upper bits wrong");
	a_version_lower: assert property (rd_ver |=> prdata[15:0] == 16'h0010)
		else $error("version lower bits wrong");
	a_present_flag: assert property (rd_ver |=> prdata[24] == $past(seen_det))
		else $error("present flag wrong");
	a_rom_reserved: assert property (rd_rom |=> prdata[30:26] == 5'h00 && !prdata[24] && prdata[15:8] == 8'h00)
		else $error("rom access reserved bits set");
	a_mini_readback: assert property (rd_rom |=> prdata[7:0] == $past(mini_rom_offset))
		else $error("mini offset readback wrong");
	a_mini_source: assert property ($changed(mini_rom_offset) && !$past(sys_hw_reset) |->
		last_addr == hvir_pkg::MINI_SRC_ADDR && mini_rom_offset == last_data)
		else $error("mini offset not from its eeprom byte");
	a_mini_valid: assert property (mini_rom_valid == (mini_rom_offset > hvir_pkg::MINI_VALID_MIN))
		else $error("mini valid wrong");
	a_bib_autoload: assert property ($fell(sys_hw_reset) && seen_det |-> ##[1:400] bib_valid)
		else $error("no autoload after hardware reset");
	a_bib_byte: assert property (bib_valid |-> bib_byte == last_data && bib_index == last_addr - BIB_BASE)
		else $error("bus info byte wrong");
	a_req_hold: assert property (rom_cmd.req && !rom_rsp.ack && !sys_hw_reset |=> rom_cmd.req && $stable(rom_cmd.addr))
		else $error("eeprom request dropped");
endmodule
bind hvir_top hvir_top_chk #(.BIB_BASE(BIB_BASE)) chk_u (.pclk, .presetn, .sys_hw_reset, .psel, .penable, .pwrite,
	.paddr, .prdata, .eeprom_detect, .rom_cmd, .rom_rsp, .bib_valid, .bib_index, .bib_byte, .mini_rom_offset,
	.mini_rom_valid);

// [test/tb_top.sv]
// self-checking bench for the version and id rom access block
// assumes the eeprom model beside the design and the bound checker
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] MINI_VAL = 8'h40;
	localparam logic [32:0] ALL = 33'h1_ffff_ffff;
	typedef struct {
		string name;
		logic [32:0] val;
		logic [32:0] mask;
	} hvir_tb_exp_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic sys_hw_reset = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic eeprom_detect = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] dly = 4'h0;
	logic [31:0] prdata, rd_val;
	logic pready, pslverr, bib_valid, bib_loaded, mini_rom_valid;
	logic [7:0] bib_index, bib_byte, mini_rom_offset;
	hvir_pkg::hvir_rom_cmd_s rom_cmd;
	hvir_pkg::hvir_rom_rsp_s rom_rsp;
	int error_cnt = 0;
	int compares = 0;
	int bib_cnt = 0;
	hvir_tb_exp_s exp_q[$];
	hvir_tb_exp_s e;
	always #25 pclk = ~pclk;
	hvir_top dut_u (.pclk, .presetn, .sys_hw_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .eeprom_detect, .rom_cmd, .rom_rsp, .bib_valid, .bib_index, .bib_byte, .bib_loaded,
		.mini_rom_offset, .mini_rom_valid);
	hvir_eeprom_model #(.MINI_VAL(MINI_VAL)) mem_u (.pclk, .presetn, .dly, .rom_cmd, .rom_rsp);
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [7:0] rom_val(input logic [7:0] a);
		return (a == 8'h28) ? MINI_VAL : a ^ 8'ha5;
	endfunction
	task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic hang();
		error_cnt++;
		test_done();
	endtask
	// apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd_val = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) hang();
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [32:0] val, input logic [32:0] mask);
		exp_q.push_back('{what, val, mask});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			rd("poll", 8'h04, 33'h0, 33'h0);
			n++;
		end while ((rd_val[31] | rd_val[25]) !== 1'b0 && n < 100);
		if (n >= 100) hang();
	endtask
	task automatic val_chk(input logic [7:0] d);
		rd("rom access", 8'h04, {9'h000, d, 8'h00, MINI_VAL}, ALL);
	endtask
	task automatic req(input logic [31:0] d);
		apb(1'b1, 8'h04, d);
		wait_idle();
	endtask
	// hardware reset pulse, then wait for autoload to end
	task automatic autoload();
		int n;
		n = 0;
		bib_cnt = 0;
		sys_hw_reset <= 1'b1;
		@(posedge pclk);
		sys_hw_reset <= 1'b0;
		do begin
			@(posedge pclk);
			n++;
		end while ((bib_loaded !== 1'b1 || mini_rom_offset !== MINI_VAL) && n < 2000);
		if (n >= 2000) hang();
		repeat (3) @(posedge pclk);
		chk("bib count", 33'd20, 33'(bib_cnt));
		chk("mini valid", 33'h1, {32'h0, mini_rom_valid});
	endtask
	// ****************************************************************
	// result watcher
	// ****************************************************************
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				chk("unexpected read", 33'h0, 33'h1);
			end else begin
				e = exp_q.pop_front();
				chk(e.name, e.val, {pslverr, prdata} & e.mask);
			end
		end
		if (bib_valid === 1'b1) begin
			bib_cnt++;
			chk("bib byte", {25'h0, rom_val(bib_index + hvir_pkg::BIB_BASE)}, {25'h0, bib_byte});
		end
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'h9e5ce379));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd("version", 8'h00, 33'h0_0001_0010, ALL);
		apb(1'b1, 8'h00, 32'hffff_ffff);
		apb(1'b1, 8'h04, 32'h00ff_00ff);
		rd("version kept", 8'h00, 33'h0_0001_0010, ALL);
		rd("rom default", 8'h04, 33'h0, ALL);
		rd("unmapped", 8'h08, 33'h1_0000_0000, ALL);
		dly <= 4'($urandom);
		eeprom_detect <= 1'b1;
		@(posedge pclk);
		eeprom_detect <= 1'b0;
		autoload();
		rd("version present", 8'h00, 33'h0_0101_0010, ALL);
		apb(1'b1, 8'h04, $urandom & 32'h7dff_ffff);
		val_chk(8'h00);
		req(32'h8000_0000);
		for (int i = 0; i < 4; i++) begin
			dly <= 4'($urandom);
			req(32'h0200_0000);
			val_chk(rom_val(8'(i)));
		end
		req(32'h8000_0000);
		val_chk(rom_val(8'h03));
		req(32'h0200_0000);
		val_chk(rom_val(8'h00));
		dly <= 4'hf;
		apb(1'b1, 8'h04, 32'h0200_0000);
		req(32'h8000_0000);
		val_chk(rom_val(8'h01));
		req(32'h0200_0000);
		val_chk(rom_val(8'h02));
		req(32'h8200_0000);
		val_chk(rom_val(8'h00));
		autoload();
		rd("flag kept", 8'h00, 33'h0_0101_0010, ALL);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd("flag cleared", 8'h00, 33'h0_0001_0010, ALL);
		rd("mini cleared", 8'h04, 33'h0, ALL);
		chk("mini invalid", 33'h0, {32'h0, mini_rom_valid});
		chk("bib cleared", 33'h0, {32'h0, bib_loaded});
		test_done();
	end
endmodule
